// ---- rtl/spr_pkg.sv ----
// What this block does
// - Busy bit reads one during ratio update
// - Align off: pending ratio switches right after go
// - Align on: go realigns clock, loads programmed ratio
// - Different ratio written sets change pending flag
// - Update changes ratio only when flag set
// - Flag clear at go: clock keeps old ratio
// - Running bit shows output clock on or gated
// - Unused register bits read zero, ignore writes
// - Memory bus clock is ten times reference
// - Controller data clock is processor clock over three
// - Writing go one starts update; bit stays set
// - Ratio code one divides two, four divides five
// - Divider enable zero stops output clock
package spr_pkg;
  localparam logic [31:0] ADDR_DIVIDER = 32'h029c0118;
  localparam logic [31:0] ADDR_COMMAND = 32'h029c0138;
  localparam logic [31:0] ADDR_STATUS = 32'h029c013c;
  localparam logic [31:0] ADDR_ALIGN = 32'h029c0140;
  localparam logic [31:0] ADDR_CHANGE = 32'h029c0144;
  localparam logic [31:0] ADDR_CLKSTAT = 32'h029c0150;

  localparam int DIV_EN_BIT = 15;
  localparam int RATIO_MSB = 4;
  localparam int RATIO_W = 5;
  localparam int FLAG_BIT = 0;

  localparam logic [RATIO_W-1:0] RATIO_DIV2 = 5'h01;
  localparam logic [RATIO_W-1:0] RATIO_DIV5 = 5'h04;
  localparam logic [RATIO_W-1:0] RATIO_DIV3 = 5'h02;
  localparam logic [RATIO_W-1:0] RATIO_RST = 5'h01;
  localparam logic DIV_EN_RST = 1'b1;
  localparam logic ALIGN_RST = 1'b0;

  localparam logic [3:0] MEM_BUS_MULT = 4'ha;

  typedef enum logic [1:0] {
    SPR_IDLE = 2'b00,
    SPR_APPLY = 2'b01,
    SPR_FINISH = 2'b10
  } spr_go_state_e;
endpackage

// ---- rtl/spr_clk_div.sv ----
`timescale 1ns/1ps
module spr_clk_div #(
  parameter logic [4:0] RST_RATIO = 5'h01
) (
  input wire logic core_clk, // Processor clock.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic div_en, // Divider enable.
  input wire logic [4:0] ratio, // Ratio code, divide by code plus one.
  input wire logic load, // Take the ratio now.
  input wire logic align, // Restart the output phase.
  output logic clk_out, // Divided clock.
  output logic running // Output clock is on.
);
  import spr_pkg::*;

  logic [4:0] ratio_reg, ratio_next;
  logic [4:0] cnt_reg, cnt_next;
  logic out_reg, out_next;
  logic run_reg, run_next;
  logic [5:0] half;

  always_comb
  begin
    ratio_next = load ? ratio : ratio_reg;
    // A shorter ratio may leave the count past its end, so it restarts then.
    if (align || cnt_reg >= ratio_next)
      cnt_next = '0;
    else
      cnt_next = cnt_reg + 5'h01;
    half = ({1'b0, ratio_next} + 6'h01) >> 1;
    out_next = div_en && ({1'b0, cnt_next} < half);
    run_next = div_en;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ratio_reg <= RST_RATIO;
      cnt_reg <= '0;
      out_reg <= 1'b0;
      run_reg <= 1'b0;
    end
    else
    begin
      ratio_reg <= ratio_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
      run_reg <= run_next;
    end
  end

  assign clk_out = out_reg;
  assign running = run_reg;
endmodule // spr_clk_div

// ---- rtl/spr_ratio_ctrl.sv ----
`timescale 1ns/1ps
module spr_ratio_ctrl (
  input wire logic core_clk, // Processor clock, 40 MHz.
  input wire logic rst, // Asynchronous reset, active high.
  input wire logic [31:0] reg_addr, // Register byte address.
  input wire logic reg_wr, // Write strobe, one cycle.
  input wire logic reg_rd, // Read strobe, one cycle.
  input wire logic [31:0] reg_wdata, // Write data.
  output logic [31:0] reg_rdata, // Read data, one cycle after the strobe.
  output logic output_clock, // Divided output clock.
  output logic ddr_data_clk, // Memory controller data clock.
  output logic [3:0] mem_bus_mult, // Multiplier setting for the memory bus clock.
  output logic go_in_progress // Ratio update under way.
);
  import spr_pkg::*;

  logic div_en_reg, div_en_next;
  logic [RATIO_W-1:0] ratio_reg, ratio_next;
  logic align_en_reg, align_en_next;
  logic go_bit_reg, go_bit_next;
  logic pending_reg, pending_next;
  spr_go_state_e state_reg, state_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_div, wr_cmd, wr_aln, start, pend_set;
  logic div_load, div_align, clk_running;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  assign wr_div = reg_wr && reg_addr == ADDR_DIVIDER;
  assign wr_cmd = reg_wr && reg_addr == ADDR_COMMAND;
  assign wr_aln = reg_wr && reg_addr == ADDR_ALIGN;
  // A go while busy is dropped; software is expected to poll first.
  assign start = wr_cmd && reg_wdata[FLAG_BIT] && state_reg == SPR_IDLE;
  assign pend_set = wr_div && reg_wdata[RATIO_MSB:0] != ratio_reg;

  go_start_a: assert property (
    wr_cmd && reg_wdata[FLAG_BIT] && !go_in_progress
    |=> go_in_progress)
    else $error("go write did not start an update");

  always_comb
  begin
    div_en_next = div_en_reg;
    ratio_next = ratio_reg;
    align_en_next = align_en_reg;
    go_bit_next = go_bit_reg;
    if (wr_div)
    begin
      div_en_next = reg_wdata[DIV_EN_BIT];
      ratio_next = reg_wdata[RATIO_MSB:0];
    end
    if (wr_aln)
      align_en_next = reg_wdata[FLAG_BIT];
    if (wr_cmd)
      go_bit_next = reg_wdata[FLAG_BIT];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      div_en_reg <= DIV_EN_RST;
      ratio_reg <= RATIO_RST;
      align_en_reg <= ALIGN_RST;
      go_bit_reg <= 1'b0;
    end
    else
    begin
      div_en_reg <= div_en_next;
      ratio_reg <= ratio_next;
      align_en_reg <= align_en_next;
      go_bit_reg <= go_bit_next;
    end
  end

  ratio_store_a: assert property (
    wr_div
    |=> ratio_reg == $past(reg_wdata[RATIO_MSB:0]))
    else $error("ratio field not stored");

  en_store_a: assert property (
    wr_div
    |=> div_en_reg == $past(reg_wdata[DIV_EN_BIT]))
    else $error("enable bit not stored");

  align_store_a: assert property (
    wr_aln
    |=> align_en_reg == $past(reg_wdata[FLAG_BIT]))
    else $error("align bit not stored");

  go_write_a: assert property (
    wr_cmd
    |=> go_bit_reg == $past(reg_wdata[FLAG_BIT]))
    else $error("go bit not stored");

  // The go bit is a plain stored bit; only a write may lower it.
  go_bit_keep_a: assert property (
    go_bit_reg && !wr_cmd
    |=> go_bit_reg)
    else $error("go bit dropped without a write");

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      SPR_IDLE:
        if (start)
          state_next = SPR_APPLY;
      SPR_APPLY:
        state_next = SPR_FINISH;
      SPR_FINISH:
        state_next = SPR_IDLE;
      default:
        state_next = SPR_IDLE;
    endcase
    // A new ratio written while the update ends must stay flagged.
    if (pend_set)
      pending_next = 1'b1;
    else if (state_reg == SPR_FINISH)
      pending_next = 1'b0;
    else
      pending_next = pending_reg;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pending_reg <= 1'b0;
      state_reg <= SPR_IDLE;
    end
    else
    begin
      pending_reg <= pending_next;
      state_reg <= state_next;
    end
  end

  go_busy_span_a: assert property (
    start
    |=> go_in_progress ##1 go_in_progress ##1 !go_in_progress)
    else $error("busy bit span wrong");

  pend_set_a: assert property (
    pend_set
    |=> pending_reg)
    else $error("pending flag not set");

  pend_clear_a: assert property (
    state_reg == SPR_FINISH && !pend_set
    |=> !pending_reg && !go_in_progress)
    else $error("pending flag not cleared at end");

  pend_hold_a: assert property (
    pending_reg && state_reg != SPR_FINISH
    |=> pending_reg)
    else $error("pending flag lost before update end");

  pend_only_wr_a: assert property (
    !pending_reg && !wr_div
    |=> !pending_reg)
    else $error("pending flag set without a divider write");

  assign div_load = state_reg == SPR_APPLY && (pending_reg || align_en_reg);
  assign div_align = state_reg == SPR_APPLY && align_en_reg;

  // With nothing pending and no alignment, neither ratio nor phase may move.
  keep_ratio_a: assert property (
    state_reg == SPR_APPLY && !pending_reg && !align_en_reg
    |=> u_out_div.ratio_reg == $past(u_out_div.ratio_reg)
      && (u_out_div.cnt_reg != '0 || $past(u_out_div.cnt_reg) >= $past(u_out_div.ratio_reg)))
    else $error("ratio changed without pending flag");

  apply_ratio_a: assert property (
    start && pending_reg && !pend_set
    |=> div_load)
    else $error("pending ratio not applied");

  align_go_a: assert property (
    start && align_en_reg && !wr_aln
    |=> div_align && div_load)
    else $error("no alignment on go");

  always_comb
  begin
    rdata_next = '0;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_DIVIDER:
        begin
          rdata_next[DIV_EN_BIT] = div_en_reg;
          rdata_next[RATIO_MSB:0] = ratio_reg;
        end
        ADDR_COMMAND:
          rdata_next[FLAG_BIT] = go_bit_reg;
        ADDR_STATUS:
          rdata_next[FLAG_BIT] = state_reg != SPR_IDLE;
        ADDR_ALIGN:
          rdata_next[FLAG_BIT] = align_en_reg;
        ADDR_CHANGE:
          rdata_next[FLAG_BIT] = pending_reg;
        ADDR_CLKSTAT:
          rdata_next[FLAG_BIT] = clk_running;
        default:
          rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  resv_zero_a: assert property (
    reg_rd
    |=> reg_rdata[31:16] == 16'h0000 && reg_rdata[14:5] == 10'h000)
    else $error("reserved bits read nonzero");

  idle_rdata_a: assert property (
    !reg_rd
    |=> reg_rdata == 32'h0)
    else $error("read data stands without a read");

  status_read_a: assert property (
    reg_rd && reg_addr == ADDR_STATUS
    |=> reg_rdata == {31'h0, $past(go_in_progress)})
    else $error("status register read wrong");

  change_read_a: assert property (
    reg_rd && reg_addr == ADDR_CHANGE
    |=> reg_rdata == {31'h0, $past(pending_reg)})
    else $error("change register read wrong");

  clk_stat_read_a: assert property (
    reg_rd && reg_addr == ADDR_CLKSTAT
    |=> reg_rdata == {31'h0, $past(clk_running)})
    else $error("clock status read wrong");

  div_read_a: assert property (
    reg_rd && reg_addr == ADDR_DIVIDER
    |=> reg_rdata[RATIO_MSB:0] == $past(ratio_reg) && reg_rdata[DIV_EN_BIT] == $past(div_en_reg))
    else $error("divider register read wrong");

  ro_change_a: assert property (
    reg_wr && reg_addr == ADDR_CHANGE && state_reg != SPR_FINISH
    |=> pending_reg == $past(pending_reg))
    else $error("write reached the change flags");

  ro_status_a: assert property (
    reg_wr && reg_addr == ADDR_STATUS && state_reg == SPR_IDLE
    |=> !go_in_progress)
    else $error("write reached the status bit");

  spr_clk_div #(.RST_RATIO(RATIO_RST)) u_out_div (
    .core_clk(core_clk),
    .rst(rst),
    .div_en(div_en_reg),
    .ratio(ratio_reg),
    .load(div_load),
    .align(div_align),
    .clk_out(output_clock),
    .running(clk_running)
  );

  // Fixed divide by three of the processor clock for the memory controller.
  spr_clk_div #(.RST_RATIO(RATIO_DIV3)) u_ddr_div (
    .core_clk(core_clk),
    .rst(rst),
    .div_en(1'b1),
    .ratio(RATIO_DIV3),
    .load(1'b0),
    .align(1'b0),
    .clk_out(ddr_data_clk),
    .running()
  );

  // The multiplying loop itself is analog; only its setting leaves here.
  assign mem_bus_mult = MEM_BUS_MULT;
  assign go_in_progress = state_reg != SPR_IDLE;
  assign reg_rdata = rdata_reg;

  // The running bit lags the enable by one cycle, so both are checked one edge on.
  gated_clk_a: assert property (
    !div_en_reg
    |=> !output_clock && !clk_running)
    else $error("clock runs while disabled");

  en_running_a: assert property (
    div_en_reg
    |=> clk_running)
    else $error("running bit low while enabled");

  div_ratio_a: assert property (
    div_load
    |=> u_out_div.ratio_reg == $past(ratio_reg))
    else $error("divider did not take the new ratio");

  align_phase_a: assert property (
    div_align && div_en_reg && ratio_reg != '0
    |=> output_clock)
    else $error("alignment did not restart the phase");

  ddr_div3_a: assert property (
    $rose(ddr_data_clk)
    |=> !ddr_data_clk ##1 !ddr_data_clk ##1 ddr_data_clk)
    else $error("data clock not divide by three");
endmodule // spr_ratio_ctrl

// ---- test/spr_ratio_ctrl_tb.sv ----
`timescale 1ns/1ps
module testbench;
  import spr_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] reg_addr = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic output_clock;
  logic ddr_data_clk;
  logic [3:0] mem_bus_mult;
  logic go_in_progress;
  int n_errors = 0;
  int tests_run = 0;
  int m_ratio = 1;
  int m_pend = 0;
  int rl[6];
  int i;
  int acc;
  logic [31:0] ta[8] = '{ADDR_ALIGN, ADDR_ALIGN, ADDR_CHANGE, ADDR_STATUS, ADDR_CLKSTAT, 32'h029c0148, ADDR_COMMAND,
    ADDR_DIVIDER};
  logic [31:0] tw[8] = '{32'hffffffff, 32'h0, 32'hffffffff, 32'hffffffff, 32'h0, 32'hffffffff, 32'hfffffffe,
    32'hffffffe1};
  logic [31:0] tr[8] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h8001};
  logic [31:0] te[8] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h1, 32'h0, 32'h0, 32'h8001};
  always #12.5 core_clk = ~core_clk;
  spr_ratio_ctrl spr_ratio_ctrl_inst (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .output_clock(output_clock),
    .ddr_data_clk(ddr_data_clk), .mem_bus_mult(mem_bus_mult), .go_in_progress(go_in_progress));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic cyc();
    @(posedge core_clk);
    #1;
  endtask
  // Each access ends one edge later so no strobe is driven twice in one step.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc();
    reg_wr = 1'b0;
    cyc();
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc();
    reg_rd = 1'b0;
    check(reg_rdata, exp);
    cyc();
  endtask
  task automatic per(input int exp);
    int n;
    int k;
    logic p;
    for (n = 0; n < 80 && output_clock !== 1'b0; n++) cyc();
    for (n = 0; n < 80 && output_clock !== 1'b1; n++) cyc();
    k = 0;
    do
    begin
      p = output_clock;
      cyc();
      k++;
    end while (k < 80 && !(p === 1'b0 && output_clock === 1'b1));
    check(k, exp);
  endtask
  task automatic go();
    rd(ADDR_STATUS, 32'h0);
    wr(ADDR_COMMAND, 32'h1);
    check(go_in_progress, 1'b1);
    cyc();
    check(go_in_progress, 1'b0);
    m_pend = 0;
    rd(ADDR_CHANGE, 32'h0);
    rd(ADDR_COMMAND, 32'h1);
    per(m_ratio + 1);
  endtask
  initial
  begin
    i = $urandom(59933);
    repeat (10) @(posedge core_clk);
    #1;
    rst = 1'b0;
    cyc();
    check(mem_bus_mult, 4'ha);
    for (i = 0; i < 6 && ddr_data_clk !== 1'b1; i++) cyc();
    for (i = 0; i < 3; i++)
    begin
      cyc();
      check(ddr_data_clk, i == 2);
    end
    rd(ADDR_DIVIDER, 32'h00008001);
    for (i = 0; i < 8; i++)
    begin
      rd(ta[i], tr[i]);
      wr(ta[i], tw[i]);
      rd(ta[i], te[i]);
    end
    rl[0] = RATIO_DIV2;
    rl[1] = RATIO_DIV5;
    for (i = 2; i < 6; i++) rl[i] = $urandom_range(31, 1);
    for (i = 0; i < 6; i++)
    begin
      if (i == 1) wr(ADDR_ALIGN, 32'h1);
      wr(ADDR_DIVIDER, 32'h8000 | rl[i]);
      if (rl[i] != m_ratio) m_pend = 1;
      m_ratio = rl[i];
      rd(ADDR_CHANGE, m_pend);
      go();
      if (i == 1) wr(ADDR_ALIGN, 32'h0);
      go();
    end
    wr(ADDR_DIVIDER, m_ratio);
    rd(ADDR_CLKSTAT, 32'h0);
    acc = 0;
    repeat (8)
    begin
      cyc();
      acc = acc | (output_clock !== 1'b0);
    end
    check(acc, 0);
    rd(ADDR_CHANGE, 32'h0);
    wr(ADDR_DIVIDER, 32'h8000 | m_ratio);
    rd(ADDR_CLKSTAT, 32'h1);
    per(m_ratio + 1);
    rst = 1'b1;
    cyc();
    check(go_in_progress, 1'b0);
    check(output_clock, 1'b0);
    rst = 1'b0;
    cyc();
    rd(ADDR_DIVIDER, 32'h00008001);
    rd(ADDR_COMMAND, 32'h0);
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    conclude();
  end
endmodule // testbench
